// [src/i2cm_master.sv]
// byte-oriented i2c master with control and shift-data registers
// assumes classic wishbone, open-drain scl/sda resolved outside, pull-ups
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
// Summary of operation
// - eight-bit shift register holds byte on bus
// - data write while open sends one byte
// - data read while open receives one byte
// - receive acknowledge driven from ack out select
// - done flag set after every byte frame
module i2cm_master
  import i2cm_pkg::*;
#(
  parameter int HALF0 = HALF_DIV0,
  parameter int HALF1 = HALF_DIV1,
  parameter int HALF2 = HALF_DIV2,
  parameter int HALF3 = HALF_DIV3
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // interrupt
  output logic             irq_o,
  // i2c pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  import i2cm_pkg::*;

  logic [7:0]      ctrl_reg;
  logic [7:0]      shift_reg;
  logic [1:0]      irq_stat_reg;
  logic [1:0]      irq_mask_reg;
  logic            ack_reg;
  logic [31:0]     rdat_reg;
  i2cm_state_t     state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0]      bit_reg;
  logic            rx_reg;
  logic            scl_s;
  logic            sda_s;
  logic            tick;
  logic            bus_req;
  logic            bus_do;
  logic [7:0]      bus_idx;
  logic            wr_ctrl;
  logic            wr_data;
  logic            rd_data;
  logic            wr_mask;
  logic            rd_stat;
  logic            byte_end;
  logic            nack_ev;

  // pins are asynchronous to clk_i
  i2cm_sync u_scl_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (scl_i),
    .level_o (scl_s)
  );
  i2cm_sync u_sda_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (sda_i),
    .level_o (sda_s)
  );

  // half bus-clock period for a divider code
  function automatic logic [CNT_W-1:0] half_cnt(input logic [1:0] code);
    case (code)
      2'h0:    half_cnt = CNT_W'(HALF0 - 1);
      2'h1:    half_cnt = CNT_W'(HALF1 - 1);
      2'h2:    half_cnt = CNT_W'(HALF2 - 1);
      default: half_cnt = CNT_W'(HALF3 - 1);
    endcase
  endfunction

  // bus decode; effects land on the edge where ack is high
  assign bus_req = cyc_i & stb_i;
  assign bus_do  = bus_req & ack_reg;
  assign bus_idx = adr_i[ADDR_LSB+7:ADDR_LSB];
  assign wr_ctrl = bus_do & we_i & sel_i[0] & (bus_idx == IDX_CONTROL);
  assign wr_data = bus_do & we_i & sel_i[0] & (bus_idx == IDX_SHIFT_DATA);
  assign wr_mask = bus_do & we_i & sel_i[0] & (bus_idx == IDX_IRQ_MASK);
  assign rd_data = bus_do & ~we_i & (bus_idx == IDX_SHIFT_DATA);
  assign rd_stat = bus_do & ~we_i & (bus_idx == IDX_IRQ_STATUS);
  assign ack_o   = ack_reg;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  // read data captured ahead of ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_reg <= 32'h0000_0000;
    else if (bus_req & ~ack_reg)
      case (bus_idx)
        IDX_CONTROL:    rdat_reg <= {24'h000000, ctrl_reg};
        IDX_SHIFT_DATA: rdat_reg <= {24'h000000, shift_reg};
        IDX_IRQ_STATUS: rdat_reg <= {30'h0, irq_stat_reg};
        IDX_IRQ_MASK:   rdat_reg <= {30'h0, irq_mask_reg};
        default:        rdat_reg <= 32'h0000_0000;
      endcase
  end
  assign dat_o = rdat_reg;

  // events from the byte engine
  assign byte_end = (state_reg == ST_HIGH) & tick & scl_s
                    & (bit_reg == ACK_SLOT);
  assign nack_ev  = byte_end & ~rx_reg & sda_s;

  // control register; done flag set wins over a zero write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CONTROL_RST;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg[BIT_ENABLE]  <= dat_i[BIT_ENABLE];
        ctrl_reg[BIT_ACK_OUT] <= dat_i[BIT_ACK_OUT];
        ctrl_reg[BIT_START]   <= dat_i[BIT_START];
        ctrl_reg[BIT_STOP]    <= dat_i[BIT_STOP];
        ctrl_reg[BIT_DIV_HI:BIT_DIV_LO] <= dat_i[BIT_DIV_HI:BIT_DIV_LO];
        if (!dat_i[BIT_DONE])
          ctrl_reg[BIT_DONE] <= 1'b0;
      end
      if (byte_end)
        ctrl_reg[BIT_DONE] <= 1'b1;
      if (byte_end & ~rx_reg)
        ctrl_reg[BIT_ACK_IN] <= sda_s;
    end
  end

  // sticky interrupt status, cleared by reading it; set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= IRQ_RST;
    else
    begin
      irq_stat_reg[IRQ_DONE] <= byte_end | (irq_stat_reg[IRQ_DONE] & ~rd_stat);
      irq_stat_reg[IRQ_NACK] <= nack_ev | (irq_stat_reg[IRQ_NACK] & ~rd_stat);
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= IRQ_RST;
    else if (wr_mask)
      irq_mask_reg <= dat_i[1:0];
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // half-period timer; in the high phase it waits while a slave stretches
  assign tick = (cnt_reg == '0);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= half_cnt(2'h0);
    else if (tick || state_reg == ST_IDLE || state_reg == ST_HOLD
             || (state_reg == ST_HIGH && !scl_s))
      cnt_reg <= half_cnt(ctrl_reg[BIT_DIV_HI:BIT_DIV_LO]);
    else
      cnt_reg <= cnt_reg - 1'b1;
  end

  // shift register: bus writes in any state but the low and high bit phases, bus samples while busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shift_reg <= DATA_RST;
    else if (wr_data && state_reg != ST_LOW && state_reg != ST_HIGH)
      shift_reg <= dat_i[7:0];
    else if (state_reg == ST_HIGH && tick && scl_s && bit_reg != ACK_SLOT)
      shift_reg <= {shift_reg[6:0], sda_s};
  end

  // byte engine; stop or cleared start ends the transfer from hold
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ctrl_reg[BIT_ENABLE])
    begin
      state_reg <= ST_IDLE;
      scl_oe_o  <= 1'b0;
      sda_oe_o  <= 1'b0;
      bit_reg   <= 4'h0;
      rx_reg    <= 1'b0;
    end
    else
      unique case (state_reg)
        ST_IDLE:
          if (ctrl_reg[BIT_START] && !ctrl_reg[BIT_STOP])
          begin
            state_reg <= ST_START;
            sda_oe_o  <= 1'b1; // start: sda falls with scl high
          end
        ST_START:
          if (tick)
          begin
            state_reg <= ST_LOW;
            scl_oe_o  <= 1'b1;
            sda_oe_o  <= ~shift_reg[7]; // address byte goes first
            bit_reg   <= 4'h0;
            rx_reg    <= 1'b0;
          end
        ST_LOW:
          if (tick)
          begin
            state_reg <= ST_HIGH;
            scl_oe_o  <= 1'b0;
          end
        ST_HIGH:
          if (tick && scl_s)
          begin
            scl_oe_o <= 1'b1;
            if (bit_reg == ACK_SLOT)
              state_reg <= ST_HOLD; // scl stays low until firmware acts
            else
            begin
              state_reg <= ST_LOW;
              bit_reg   <= bit_reg + 1'b1;
              if (bit_reg == LAST_DATA_BIT)
                sda_oe_o <= rx_reg & ~ctrl_reg[BIT_ACK_OUT];
              else
                sda_oe_o <= ~rx_reg & ~shift_reg[6];
            end
          end
        ST_HOLD:
          if (ctrl_reg[BIT_STOP] || !ctrl_reg[BIT_START])
          begin
            state_reg <= ST_STOPL;
            sda_oe_o  <= 1'b1;
          end
          else if (wr_data)
          begin
            state_reg <= ST_LOW;
            sda_oe_o  <= ~dat_i[7];
            bit_reg   <= 4'h0;
            rx_reg    <= 1'b0;
          end
          else if (rd_data)
          begin
            state_reg <= ST_LOW;
            sda_oe_o  <= 1'b0;
            bit_reg   <= 4'h0;
            rx_reg    <= 1'b1;
          end
        ST_STOPL:
          if (tick)
          begin
            state_reg <= ST_STOPH;
            scl_oe_o  <= 1'b0;
          end
        ST_STOPH:
          if (tick && scl_s)
          begin
            state_reg <= ST_FREE;
            sda_oe_o  <= 1'b0; // stop: sda rises with scl high
          end
        ST_FREE:
          if (tick)
            state_reg <= ST_IDLE; // bus-free gap before a new start
      endcase
  end

  // open drain: the pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");
  a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i & stb_i & !ack_o) |=> ack_o) else $error("ack not in one cycle");
  a_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_end |=> ctrl_reg[BIT_DONE] && state_reg == ST_HOLD)
    else $error("done flag or hold missing after byte");
  a_ack_in_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_end & !rx_reg) |=> ctrl_reg[BIT_ACK_IN] == $past(sda_s))
    else $error("slave acknowledge not captured");
  a_tx_resume: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_HOLD && ctrl_reg[BIT_START] && !ctrl_reg[BIT_STOP]
     && wr_data) |=> state_reg == ST_LOW && !rx_reg
     && sda_oe_o == !shift_reg[7])
    else $error("write did not resume transmit");
  a_rx_resume: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_HOLD && ctrl_reg[BIT_START] && !ctrl_reg[BIT_STOP]
     && rd_data && !wr_data) |=> state_reg == ST_LOW && rx_reg && !sda_oe_o)
    else $error("read did not resume receive");
  a_data_store: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_data && state_reg == ST_IDLE) |=> shift_reg == $past(dat_i[7:0]))
    else $error("data register not written");
  a_rx_ack_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_reg && bit_reg == ACK_SLOT && state_reg == ST_LOW)
    |-> sda_oe_o == !ctrl_reg[BIT_ACK_OUT])
    else $error("receive acknowledge drive wrong");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_end && irq_mask_reg[IRQ_DONE] |=> irq_o)
    else $error("unmasked done did not raise irq");

  c_tx_byte: cover property (@(posedge clk_i) disable iff (rst_i)
    byte_end && !rx_reg);
  c_rx_byte: cover property (@(posedge clk_i) disable iff (rst_i)
    byte_end && rx_reg);
  c_stop: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_FREE);
endmodule // i2cm_master

// [src/i2cm_pkg.sv]
// constants shared by the byte-oriented i2c master block
// assumes a 32-bit classic wishbone slave port and a 100 MHz system clock
package i2cm_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL    = 8'hE1;
  localparam logic [7:0] IDX_SHIFT_DATA = 8'hE2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE3;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hE4;
  localparam int         ADDR_LSB       = 2;

  // control register bit positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_ACK_OUT  = 6;
  localparam int BIT_DONE     = 5;
  localparam int BIT_ACK_IN   = 4;
  localparam int BIT_START    = 3;
  localparam int BIT_STOP     = 2;
  localparam int BIT_DIV_HI   = 1;
  localparam int BIT_DIV_LO   = 0;

  // interrupt status and mask bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h04;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [1:0] IRQ_RST     = 2'h0;

  // half period of the bus clock in system clocks, one per divider code
  localparam int HALF_DIV0 = 125;
  localparam int HALF_DIV1 = 250;
  localparam int HALF_DIV2 = 500;
  localparam int HALF_DIV3 = 1000;
  localparam int CNT_W     = 10;

  // bits per byte frame, including the acknowledge slot
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_HOLD  = 3'b100,
    ST_STOPL = 3'b101,
    ST_STOPH = 3'b110,
    ST_FREE  = 3'b111
  } i2cm_state_t;

endpackage

// [src/i2cm_sync.sv]
// three-stage input synchroniser for pins sensed by the i2c master
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ns
module i2cm_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin in, filtered level out
  input  wire logic pin_i,
  output logic      level_o
);
  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  // chain; only s2 reads the first stage
  always_ff @(posedge clk_i)
  begin
    meta_reg <= rst_i ? 1'b1 : pin_i;
    s2_reg   <= rst_i ? 1'b1 : meta_reg;
    s3_reg   <= rst_i ? 1'b1 : s2_reg;
  end

  // level moves only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_o <= 1'b1;
    else if (s2_reg == s3_reg)
      level_o <= s3_reg;
  end
endmodule // i2cm_sync

// [tb/i2c_master_data_port_tb.sv]
// self-checking bench: wishbone register access, one slave on the lines
// assumes the master and slave model share pulled-up scl and sda
`timescale 1ns/1ns
module i2c_master_data_port_tb;
  import i2cm_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, scl_i, sda_i;
  logic [31:0] adr_i, dat_i, dat_o;
  logic [3:0]  sel_i;
  logic        ack_o, irq_o, scl_oe_o, sda_oe_o, s_oe;
  logic        nack, mack, stop_seen;
  logic [7:0]  rx, v;
  // bytes the slave returns on a read: first after address, then later
  logic [7:0]  tx_first = 8'h25;
  logic [7:0]  tx_next  = 8'hA6;
  int          n_errors = 0;
  int          checks_done = 0;
  // pull-ups: a line is low while any party pulls it
  assign scl_i = ~scl_oe_o;
  assign sda_i = ~(sda_oe_o | s_oe);
  i2cm_master #(.HALF0(6), .HALF1(7), .HALF2(8), .HALF3(9)) i2cm_master_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .scl_i(scl_i),
    .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(),
    .sda_oe_o(sda_oe_o));
  i2cm_slave_model i2cm_slave_model_inst (
    .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(s_oe), .nack_i(nack),
    .tx_a_i(tx_first), .tx_b_i(tx_next), .rx_o(rx), .mack_o(mack),
    .stop_o(stop_seen));
  // 100 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hang ends the run, well after any real sequence could have finished
  initial
  begin
    #500000;
    n_errors++;
    report_and_stop();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {22'h0, idx, 2'h0};
    dat_i <= {24'h0, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      n_errors++;
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] t;
    wb(1'b1, idx, d, t);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] t;
    wb(1'b0, idx, 8'h00, t);
    check(t, e);
  endtask
  // the flag, or the stop, must come within a bounded wait
  task automatic wait_for(input bit want_stop);
    int n;
    n = 0;
    while ((want_stop ? stop_seen : irq_o) !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    check(n < 4000, 1'b1);
  endtask
  initial
  begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, nack} = 4'h0;
    adr_i = 32'h0;
    dat_i = 32'h0;
    sel_i = 4'hF;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_CONTROL, CONTROL_RST);
    rdc(IDX_SHIFT_DATA, DATA_RST);
    rdc(8'hE0, 8'h00);
    // transmit: address, one byte acked, one byte refused
    wr(IDX_IRQ_MASK, 8'h03);
    wr(IDX_SHIFT_DATA, 8'hA0);
    rdc(IDX_SHIFT_DATA, 8'hA0);
    wr(IDX_CONTROL, 8'h88);
    wait_for(1'b0);
    wr(IDX_IRQ_MASK, 8'h00);
    @(posedge clk_i);
    check(irq_o, 1'b0);
    wr(IDX_IRQ_MASK, 8'h03);
    @(posedge clk_i);
    check(irq_o, 1'b1);
    rdc(IDX_CONTROL, 8'hA8);
    rdc(IDX_IRQ_STATUS, 8'h01);
    rdc(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_CONTROL, 8'h88);
    wr(IDX_SHIFT_DATA, 8'h3C);
    wait_for(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h01);
    check(rx, 8'h3C);
    // slowest divider code for this byte
    nack <= 1'b1;
    wr(IDX_CONTROL, 8'h8B);
    wr(IDX_SHIFT_DATA, 8'h55);
    wait_for(1'b0);
    rdc(IDX_CONTROL, 8'hBB);
    rdc(IDX_IRQ_STATUS, 8'h03);
    nack <= 1'b0;
    wr(IDX_CONTROL, 8'h84);
    wait_for(1'b1);
    // start stays low well over one bus clock period
    repeat (60) @(posedge clk_i);
    // receive: address, discarded read, two bytes
    wr(IDX_SHIFT_DATA, 8'hA1);
    wr(IDX_CONTROL, 8'h88);
    wait_for(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h01);
    // divider code two for the first received byte
    wr(IDX_CONTROL, 8'h8A);
    wb(1'b0, IDX_SHIFT_DATA, 8'h00, v);
    wait_for(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h01);
    check(mack, 1'b0);
    wr(IDX_CONTROL, 8'hC8);
    rdc(IDX_SHIFT_DATA, 8'h25);
    wait_for(1'b0);
    rdc(IDX_IRQ_STATUS, 8'h01);
    check(mack, 1'b1);
    wr(IDX_CONTROL, 8'hC4);
    rdc(IDX_SHIFT_DATA, 8'hA6);
    wait_for(1'b1);
    report_and_stop();
  end
endmodule // i2c_master_data_port_tb

// [tb/i2cm_slave_model.sv]
// behavioural i2c slave that answers the master on the shared lines
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/1ns
module i2cm_slave_model (
  // bus lines
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  // bench control and observation
  input  wire logic       nack_i,
  input  wire logic [7:0] tx_a_i,
  input  wire logic [7:0] tx_b_i,
  output logic [7:0]      rx_o,
  output logic            mack_o,
  output logic            stop_o
);
  int         bitn = 0;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  logic       fresh = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] cur = 8'h00;
  initial
  begin
    sda_oe_o = 1'b0;
    rx_o = 8'h00;
    mack_o = 1'b0;
    stop_o = 1'b0;
  end
  // start: sda falls while scl is high
  always @(negedge sda_i)
    if (scl_i)
    begin
      bitn = 0;
      first = 1'b1;
      rd = 1'b0;
      stop_o = 1'b0;
    end
  // stop: sda rises while scl is high
  always @(posedge sda_i)
    if (scl_i)
    begin
      stop_o = 1'b1;
      rd = 1'b0;
    end
  // sample on rising scl; a master nack ends our sending
  always @(posedge scl_i)
  begin
    if (bitn < 8)
      sh = {sh[6:0], sda_i};
    else if (rd)
    begin
      mack_o = sda_i;
      rd = !sda_i;
    end
    bitn = bitn + 1;
  end
  // change sda only while scl is low
  always @(negedge scl_i)
  begin
    if (bitn == 8)
      sda_oe_o = !rd && !(nack_i && !first);
    else if (bitn == 9)
    begin
      if (first)
      begin
        rd = sh[0];
        fresh = 1'b1;
      end
      else if (!rd)
        rx_o = sh;
      first = 1'b0;
      bitn = 0;
      if (rd)
        cur = fresh ? tx_a_i : tx_b_i;
      fresh = 1'b0;
      sda_oe_o = rd & ~cur[7];
    end
    else if (bitn < 8)
      sda_oe_o = rd & ~cur[7 - bitn];
  end
endmodule // i2cm_slave_model
